/* pcg_clock_gating.sv */
// module: peripheral clock gating control with apb register access
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module pcg_clock_gating
  import pcg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_req,
  input wire logic deep_sleep_req,
  input wire logic [PCG_NUNITS-1:0] unit_access,
  output logic [PCG_NUNITS-1:0] unit_fault,
  output logic [PCG_NUNITS-1:0] unit_clk_en,
  output logic [PCG_NUNITS-1:0] unit_clk,
  output logic irq
);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [31:0] run_gate_motor_analog_ff;
  logic [31:0] run_gate_serial_timers_ff;
  logic [31:0] sleep_gate_motor_analog_ff;
  logic [31:0] sleep_gate_serial_timers_ff;
  logic [31:0] deep_sleep_gate_motor_analog_ff;
  logic [31:0] deep_sleep_gate_serial_timers_ff;
  logic auto_gating_select_ff;
  pcg_units_t fault_stat_ff;
  pcg_units_t fault_mask_ff;

  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [PCG_NUNITS-1:0] unit_fault_ff;
  logic [PCG_NUNITS-1:0] unit_clk_en_ff;
  logic [PCG_NUNITS-1:0] clk_en_low_ff;
  logic irq_ff;
  logic sleep_s1_ff;
  logic sleep_s2_ff;
  logic deep_s1_ff;
  logic deep_s2_ff;
  pcg_mode_t mode_ff;
  pcg_mode_t nxt_mode;

  logic setup_phase;
  logic wr_commit;
  logic addr_hit;
  logic [31:0] rd_val;
  pcg_gate_set_t sel_set;
  pcg_units_t nxt_clk_en;
  pcg_units_t nxt_fault;

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  // one wait-free access phase: answer is prepared during setup
  assign setup_phase = psel && !penable && !pready_ff;
  assign wr_commit = psel && penable && pready_ff && pwrite && !pslverr_ff;

  function automatic logic [31:0] ro_view(input logic [31:0] val, input logic [31:0] wmask,
                                          input logic [31:0] rst);
    ro_view = (val & wmask) | (rst & ~wmask);
  endfunction

  always_comb
  begin
    addr_hit = 1'b1;
    rd_val = PCG_RST_ZERO;
    case (paddr)
      PCG_OFF_AUTO_CTRL:
      begin
        rd_val[PCG_BIT_AUTO] = auto_gating_select_ff;
      end
      PCG_OFF_RUN_MA: rd_val = ro_view(run_gate_motor_analog_ff, PCG_WMASK_MA, PCG_RST_MA);
      PCG_OFF_RUN_ST: rd_val = ro_view(run_gate_serial_timers_ff, PCG_WMASK_ST, PCG_RST_ST);
      PCG_OFF_SLEEP_MA: rd_val = ro_view(sleep_gate_motor_analog_ff, PCG_WMASK_MA, PCG_RST_MA);
      PCG_OFF_SLEEP_ST: rd_val = ro_view(sleep_gate_serial_timers_ff, PCG_WMASK_ST, PCG_RST_ST);
      // reserved bits show their reset value and ignore writes
      PCG_OFF_DEEP_MA: rd_val = ro_view(deep_sleep_gate_motor_analog_ff, PCG_WMASK_MA,
                                        PCG_RST_DEEP_MA);
      PCG_OFF_DEEP_ST: rd_val = ro_view(deep_sleep_gate_serial_timers_ff, PCG_WMASK_ST,
                                        PCG_RST_ST);
      PCG_OFF_FAULT_STAT: rd_val[PCG_NUNITS-1:0] = fault_stat_ff;
      PCG_OFF_FAULT_MASK: rd_val[PCG_NUNITS-1:0] = fault_mask_ff;
      default: addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= PCG_RST_ZERO;
    end
    else
    begin
      pready_ff <= setup_phase;
      if (setup_phase)
      begin
        pslverr_ff <= !addr_hit;
        prdata_ff <= (addr_hit && !pwrite) ? rd_val : PCG_RST_ZERO;
      end
      else
      begin
        pslverr_ff <= 1'b0;
        prdata_ff <= PCG_RST_ZERO;
      end
    end
  end

  // ------------------------------------------------------------
  // gating registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_gate_motor_analog_ff <= PCG_RST_MA;
      run_gate_serial_timers_ff <= PCG_RST_ST;
      sleep_gate_motor_analog_ff <= PCG_RST_MA;
      sleep_gate_serial_timers_ff <= PCG_RST_ST;
      deep_sleep_gate_motor_analog_ff <= PCG_RST_DEEP_MA;
      deep_sleep_gate_serial_timers_ff <= PCG_RST_ST;
      auto_gating_select_ff <= 1'b0;
    end
    else if (wr_commit)
    begin
      // only documented enables are stored
      case (paddr)
        PCG_OFF_AUTO_CTRL: auto_gating_select_ff <= pwdata[PCG_BIT_AUTO];
        PCG_OFF_RUN_MA: run_gate_motor_analog_ff <= pwdata & PCG_WMASK_MA;
        PCG_OFF_RUN_ST: run_gate_serial_timers_ff <= pwdata & PCG_WMASK_ST;
        PCG_OFF_SLEEP_MA: sleep_gate_motor_analog_ff <= pwdata & PCG_WMASK_MA;
        PCG_OFF_SLEEP_ST: sleep_gate_serial_timers_ff <= pwdata & PCG_WMASK_ST;
        PCG_OFF_DEEP_MA: deep_sleep_gate_motor_analog_ff <= pwdata & PCG_WMASK_MA;
        PCG_OFF_DEEP_ST: deep_sleep_gate_serial_timers_ff <= pwdata & PCG_WMASK_ST;
        default:
        begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // power state
  // ------------------------------------------------------------
  // sleep requests come from the power controller, treated as async
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sleep_s1_ff <= 1'b0;
      sleep_s2_ff <= 1'b0;
      deep_s1_ff <= 1'b0;
      deep_s2_ff <= 1'b0;
    end
    else
    begin
      sleep_s1_ff <= sleep_req;
      sleep_s2_ff <= sleep_s1_ff;
      deep_s1_ff <= deep_sleep_req;
      deep_s2_ff <= deep_s1_ff;
    end
  end

  always_comb
  begin
    // without auto gating the run set stays in charge
    if (!auto_gating_select_ff)
      nxt_mode = PCG_MODE_RUN;
    else if (deep_s2_ff)
      nxt_mode = PCG_MODE_DEEP;
    else if (sleep_s2_ff)
      nxt_mode = PCG_MODE_SLEEP;
    else
      nxt_mode = PCG_MODE_RUN;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_ff <= PCG_MODE_RUN;
    else
      mode_ff <= nxt_mode;
  end

  always_comb
  begin
    case (mode_ff)
      PCG_MODE_SLEEP:
      begin
        sel_set.ma = sleep_gate_motor_analog_ff;
        sel_set.st = sleep_gate_serial_timers_ff;
      end
      PCG_MODE_DEEP:
      begin
        sel_set.ma = deep_sleep_gate_motor_analog_ff;
        sel_set.st = deep_sleep_gate_serial_timers_ff;
      end
      default:
      begin
        sel_set.ma = run_gate_motor_analog_ff;
        sel_set.st = run_gate_serial_timers_ff;
      end
    endcase
  end

  // ------------------------------------------------------------
  // unit enables
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_clk_en.pwm = sel_set.ma[PCG_BIT_PWM];
    nxt_clk_en.adc = sel_set.ma[PCG_BIT_ADC];
    nxt_clk_en.wdt = sel_set.ma[PCG_BIT_WDT];
    nxt_clk_en.gp_counter_1_gate = sel_set.st[PCG_BIT_GP_COUNTER_1_GATE];
    nxt_clk_en.gp_counter_0_gate = sel_set.st[PCG_BIT_GP_COUNTER_0_GATE];
    nxt_clk_en.i2c = sel_set.st[PCG_BIT_I2C];
    nxt_clk_en.ssi = sel_set.st[PCG_BIT_SSI];
    nxt_clk_en.async_serial_1_gate = sel_set.st[PCG_BIT_ASYNC_SERIAL_1_GATE];
    nxt_clk_en.async_serial_0_gate = sel_set.st[PCG_BIT_ASYNC_SERIAL_0_GATE];
  end

  genvar gi;
  generate
    for (gi = 0; gi < PCG_NUNITS; gi = gi + 1)
    begin : g_unit
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          unit_clk_en_ff[gi] <= 1'b0;
        else
          unit_clk_en_ff[gi] <= nxt_clk_en[gi];
      end

      // enable moves only while pclk is low, so the and-gate never
      // cuts a high phase short: latch-style gating cell
      always_ff @(negedge pclk or negedge presetn)
      begin
        if (!presetn)
          clk_en_low_ff[gi] <= 1'b0;
        else
          clk_en_low_ff[gi] <= unit_clk_en_ff[gi];
      end

      assign unit_clk[gi] = pclk & clk_en_low_ff[gi];

      // an access to a stopped unit is answered with a fault
      assign nxt_fault[gi] = unit_access[gi] && !unit_clk_en_ff[gi];

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          unit_fault_ff[gi] <= 1'b0;
        else
          unit_fault_ff[gi] <= nxt_fault[gi];
      end

      // set beats a simultaneous write-one clear
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          fault_stat_ff[gi] <= 1'b0;
        else if (nxt_fault[gi])
          fault_stat_ff[gi] <= 1'b1;
        else if (wr_commit && paddr == PCG_OFF_FAULT_STAT && pwdata[gi])
          fault_stat_ff[gi] <= 1'b0;
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // interrupt
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_mask_ff <= '0;
    else if (wr_commit && paddr == PCG_OFF_FAULT_MASK)
      fault_mask_ff <= pwdata[PCG_NUNITS-1:0];
  end

  // one cycle behind the status bit, keeps the output a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(fault_stat_ff & fault_mask_ff);
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign unit_fault = unit_fault_ff;
  assign unit_clk_en = unit_clk_en_ff;
  assign irq = irq_ff;

endmodule
`default_nettype wire

/* pcg_pkg.sv */
// package: register map, field layout and types of the peripheral clock gating block
`default_nettype none
package pcg_pkg;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [11:0] PCG_OFF_AUTO_CTRL = 12'h060;
  localparam logic [11:0] PCG_OFF_RUN_MA = 12'h100;
  localparam logic [11:0] PCG_OFF_RUN_ST = 12'h104;
  localparam logic [11:0] PCG_OFF_SLEEP_MA = 12'h110;
  localparam logic [11:0] PCG_OFF_SLEEP_ST = 12'h114;
  localparam logic [11:0] PCG_OFF_DEEP_MA = 12'h120;
  localparam logic [11:0] PCG_OFF_DEEP_ST = 12'h124;
  localparam logic [11:0] PCG_OFF_FAULT_STAT = 12'h150;
  localparam logic [11:0] PCG_OFF_FAULT_MASK = 12'h154;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int PCG_BIT_PWM = 20;
  localparam int PCG_BIT_ADC = 16;
  localparam int PCG_BIT_WDT = 3;
  localparam int PCG_BIT_GP_COUNTER_1_GATE = 17;
  localparam int PCG_BIT_GP_COUNTER_0_GATE = 16;
  localparam int PCG_BIT_I2C = 12;
  localparam int PCG_BIT_SSI = 4;
  localparam int PCG_BIT_ASYNC_SERIAL_1_GATE = 1;
  localparam int PCG_BIT_ASYNC_SERIAL_0_GATE = 0;
  localparam int PCG_BIT_AUTO = 0;

  // ------------------------------------------------------------
  // writable masks and reset values
  // ------------------------------------------------------------
  localparam logic [31:0] PCG_WMASK_MA = 32'h0011_0008;
  localparam logic [31:0] PCG_WMASK_ST = 32'h0003_1013;
  localparam logic [31:0] PCG_RST_MA = 32'h0000_0000;
  localparam logic [31:0] PCG_RST_ST = 32'h0000_0000;
  localparam logic [31:0] PCG_RST_DEEP_MA = 32'h0000_0040;
  localparam logic [31:0] PCG_RST_ZERO = 32'h0000_0000;

  localparam int PCG_NUNITS = 9;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PCG_MODE_RUN = 2'h0,
    PCG_MODE_SLEEP = 2'h1,
    PCG_MODE_DEEP = 2'h3
  } pcg_mode_t;

  // one bit per gated unit; also the layout of fault status and mask
  typedef struct packed {
    logic pwm;
    logic adc;
    logic wdt;
    logic gp_counter_1_gate;
    logic gp_counter_0_gate;
    logic i2c;
    logic ssi;
    logic async_serial_1_gate;
    logic async_serial_0_gate;
  } pcg_units_t;

  typedef struct packed {
    logic [31:0] ma;
    logic [31:0] st;
  } pcg_gate_set_t;

endpackage
`default_nettype wire

/* pcg_checker.sv */
// checker: concurrent properties on the clock gating block ports
`timescale 1ns/1ps
`default_nettype none
module pcg_checker
  import pcg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep_req,
  input wire logic deep_sleep_req,
  input wire logic [PCG_NUNITS-1:0] unit_access,
  input wire logic [PCG_NUNITS-1:0] unit_fault,
  input wire logic [PCG_NUNITS-1:0] unit_clk_en,
  input wire logic [PCG_NUNITS-1:0] unit_clk,
  input wire logic irq
);
  logic mapped;
  logic acc;
  logic [2:0] run_cnt_ff;
  assign acc = psel && penable && pready;
  assign mapped = paddr inside {PCG_OFF_AUTO_CTRL, PCG_OFF_RUN_MA, PCG_OFF_RUN_ST,
    PCG_OFF_SLEEP_MA, PCG_OFF_SLEEP_ST, PCG_OFF_DEEP_MA, PCG_OFF_DEEP_ST,
    PCG_OFF_FAULT_STAT, PCG_OFF_FAULT_MASK};
  // run set trusted only once the sleep inputs passed the sync chain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_cnt_ff <= 3'h0;
    else if (sleep_req || deep_sleep_req)
      run_cnt_ff <= 3'h0;
    else if (run_cnt_ff != 3'h7)
      run_cnt_ff <= run_cnt_ff + 3'h1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY_ONE:
    assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle");
  AST_UNMAPPED_ERR:
    assert property (acc |-> pslverr == !mapped)
    else $error("pslverr wrong");
  AST_RUN_RSV:
    assert property (acc && !pwrite && paddr == PCG_OFF_RUN_ST |->
      (prdata & ~32'h0003_1013) == 32'h0000_0000)
    else $error("reserved bits set");
  AST_FAULT:
    assert property (1'b1 |=> unit_fault == $past(unit_access & ~unit_clk_en))
    else $error("unit_fault wrong");
  AST_IRQ_CAUSE:
    assert property ($rose(irq) |-> $past(|unit_fault) || $past(acc && pwrite, 2))
    else $error("irq without cause");
  AST_RUN_EN:
    assert property (acc && pwrite && paddr == PCG_OFF_RUN_ST && run_cnt_ff == 3'h7 |-> ##2
      unit_clk_en[5:0] == $past({pwdata[17:16], pwdata[12], pwdata[4], pwdata[1:0]}, 2))
    else $error("serial enables wrong");
  AST_MA_EN:
    assert property (acc && pwrite && paddr == PCG_OFF_RUN_MA && run_cnt_ff == 3'h7 |-> ##2
      unit_clk_en[8:6] == $past({pwdata[20], pwdata[16], pwdata[3]}, 2))
    else $error("motor enables wrong");
  AST_GATED_CLK:
    assert property (@(negedge pclk) disable iff (!presetn) unit_clk == $past(unit_clk_en))
    else $error("gated clock wrong");
  cover property (irq);
  cover property (|unit_fault);
  cover property (pslverr);
endmodule
bind pcg_clock_gating pcg_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
  .unit_access(unit_access), .unit_fault(unit_fault), .unit_clk_en(unit_clk_en),
  .unit_clk(unit_clk), .irq(irq));
`default_nettype wire

/* pcg_apb_host.sv */
// apb master model standing in for processor software
`timescale 1ns/1ps
`default_nettype none
module pcg_apb_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // ------------------------------------------------------------
  // one transfer, held until pready is sampled high
  // ------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the bench timeout may end a wait that never sees pready
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // stale data must not look valid after release
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

/* peripheral_clock_gating_bench.sv */
// testbench: registers, faults and power states of the clock gating block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, g) \
  begin \
    check_count++; \
    if ((g) !== (x)) \
    begin \
      error_cnt++; \
      $display("Error %s expected %h seen %h", n, x, g); \
    end \
  end
module peripheral_clock_gating_bench;
  import pcg_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_req, deep_sleep_req, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [PCG_NUNITS-1:0] unit_access, unit_fault, unit_clk_en, unit_clk;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  pcg_clock_gating dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
    .unit_access(unit_access), .unit_fault(unit_fault), .unit_clk_en(unit_clk_en),
    .unit_clk(unit_clk), .irq(irq));
  pcg_apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ------------------------------------------------------------
  // helpers and scenarios
  // ------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a);
    host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic pulse(input logic [PCG_NUNITS-1:0] m);
    @(posedge pclk);
    unit_access <= m;
    @(posedge pclk);
    unit_access <= '0;
    #1;
  endtask
  task automatic t_reset;
    rd(PCG_OFF_RUN_ST);
    `CHK("run_st", 32'h0000_0000, q)
    rd(PCG_OFF_DEEP_MA);
    `CHK("deep_ma", 32'h0000_0040, q)
    `CHK("clk_en", 9'h000, unit_clk_en)
  endtask
  task automatic t_fields;
    wr(PCG_OFF_RUN_ST, 32'hffff_ffff);
    rd(PCG_OFF_RUN_ST);
    `CHK("run_st", 32'h0003_1013, q)
    wr(PCG_OFF_DEEP_MA, 32'hffff_ffff);
    rd(PCG_OFF_DEEP_MA);
    `CHK("deep_ma", 32'h0011_0048, q)
    wr(PCG_OFF_RUN_MA, 32'h0010_0008);
    wait_cyc(3);
    `CHK("clk_en", 9'h17f, unit_clk_en)
  endtask
  task automatic t_unmapped;
    wr(12'h0fc, 32'hffff_ffff);
    `CHK("pslverr", 1'b1, e)
    rd(12'h0fc);
    `CHK("unmapped", 33'h1_0000_0000, {e, q})
  endtask
  task automatic t_fault;
    wr(PCG_OFF_RUN_ST, 32'h0);
    wr(PCG_OFF_FAULT_MASK, 32'h1);
    pulse(9'h001);
    `CHK("unit_fault", 9'h001, unit_fault)
    wait_cyc(1);
    `CHK("irq", 1'b1, irq)
    rd(PCG_OFF_FAULT_STAT);
    `CHK("fault_stat", 32'h1, q)
    wr(PCG_OFF_FAULT_STAT, 32'h1);
    wait_cyc(2);
    `CHK("irq", 1'b0, irq)
    wr(PCG_OFF_RUN_ST, 32'h1);
    pulse(9'h001);
    `CHK("unit_fault", 9'h000, unit_fault)
    pulse(9'h002);
    `CHK("unit_fault", 9'h002, unit_fault)
    wait_cyc(1);
    `CHK("irq_masked", 1'b0, irq)
    rd(PCG_OFF_FAULT_STAT);
    `CHK("fault_stat", 32'h0000_0002, q)
    rd(PCG_OFF_FAULT_MASK);
    `CHK("fault_mask", 32'h0000_0001, q)
    wr(PCG_OFF_FAULT_STAT, 32'h0000_0002);
  endtask
  task automatic t_sleep;
    wr(PCG_OFF_DEEP_ST, 32'h2);
    wr(PCG_OFF_SLEEP_MA, 32'h0001_0000);
    wr(PCG_OFF_SLEEP_ST, 32'h0000_0010);
    wr(PCG_OFF_AUTO_CTRL, 32'h1);
    rd(PCG_OFF_AUTO_CTRL);
    `CHK("auto", 32'h0000_0001, q)
    @(posedge pclk);
    sleep_req <= 1'b1;
    wait_cyc(6);
    `CHK("en_sleep", 9'h084, unit_clk_en)
    @(posedge pclk);
    deep_sleep_req <= 1'b1;
    wait_cyc(6);
    `CHK("en_deep", 9'h1c2, unit_clk_en)
    wr(PCG_OFF_AUTO_CTRL, 32'h0);
    wait_cyc(3);
    `CHK("en_no_auto", 9'h141, unit_clk_en)
    @(posedge pclk);
    sleep_req <= 1'b0;
    deep_sleep_req <= 1'b0;
    wait_cyc(8);
  endtask
  // reset in mid-run must bring written registers back to reset values
  task automatic t_midreset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    `CHK("en_rst", 9'h000, unit_clk_en)
    `CHK("irq_rst", 1'b0, irq)
    rd(PCG_OFF_RUN_MA);
    `CHK("run_ma_rst", 32'h0000_0000, q)
    rd(PCG_OFF_DEEP_MA);
    `CHK("deep_ma_rst", 32'h0000_0040, q)
    rd(PCG_OFF_RUN_ST);
    `CHK("run_st_rst", 32'h0000_0000, q)
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  initial
  begin
    presetn = 1'b0;
    sleep_req = 1'b0;
    deep_sleep_req = 1'b0;
    unit_access = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_fields();
    t_unmapped();
    t_fault();
    t_sleep();
    t_midreset();
    print_verdict();
  end
endmodule
`default_nettype wire
